// ### bridge_cfg_bus_io_regs.sv
// configuration registers 0Eh..1Dh with bus and io window decode
`default_nettype none

module bridge_cfg_bus_io_regs
    import bridge_cfg_pkg::*;
#(
    parameter int LAT_W = 8
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // configuration access from the upstream bus
    input wire cfg_req_t i_cfg,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    // upper io window halves from their own registers
    input wire logic [15:0] i_io_start_upper,
    input wire logic [15:0] i_io_end_upper,
    // type 1 configuration cycle seen on the upstream bus
    input wire cfg_fwd_req_t i_fwd,
    output logic o_fwd_done,
    output fwd_kind_t o_fwd_kind,
    // io transaction seen on the upstream bus
    input wire logic i_io_valid,
    input wire logic [31:0] i_io_addr,
    output logic o_io_done,
    output logic o_io_fwd,
    // downstream initiator control
    input wire logic i_sec_frame_start,
    input wire logic i_sec_txn_end,
    input wire logic i_other_master_req,
    output logic o_sec_gnt,
    output logic o_lat_expired,
    output logic o_sec_terminate
);

    if (LAT_W != 8) begin : g_chk
        $error("bridge_cfg_bus_io_regs: latency timer must be 8 bits");
    end

    // ------------------------------------------------------------
    // byte lane helpers
    // ------------------------------------------------------------
    function automatic logic lane_hit(input cfg_req_t r, input logic [7:0] off);
        lane_hit = r.wr && (r.addr[7:2] == off[7:2]) && r.be[off[1:0]];
    endfunction

    function automatic logic [7:0] lane_data(input cfg_req_t r, input logic [7:0] off);
        lane_data = r.wdata[8*off[1:0] +: 8];
    endfunction

    function automatic logic [31:0] place(input logic [7:0] b, input logic [7:0] off);
        place = {24'h00_0000, b} << (8 * off[1:0]);
    endfunction

    // ------------------------------------------------------------
    // writable state
    // ------------------------------------------------------------
    logic [7:0] up_bus_q, up_bus_d;
    logic [7:0] dn_bus_q, dn_bus_d;
    logic [7:0] high_bus_q, high_bus_d;
    logic [7:0] lat_q, lat_d;
    logic [3:0] io_start_nib_q, io_start_nib_d;
    logic [3:0] io_end_nib_q, io_end_nib_d;

    wire logic wr_up = lane_hit(i_cfg, OFF_UP_BUS);
    wire logic wr_dn = lane_hit(i_cfg, OFF_DN_BUS);
    wire logic wr_high = lane_hit(i_cfg, OFF_HIGH_BUS);
    wire logic wr_lat = lane_hit(i_cfg, OFF_LAT_TIMER);
    wire logic wr_io_start = lane_hit(i_cfg, OFF_IO_START);
    wire logic wr_io_end = lane_hit(i_cfg, OFF_IO_END);

    wire logic [7:0] io_start_wbyte = lane_data(i_cfg, OFF_IO_START);
    wire logic [7:0] io_end_wbyte = lane_data(i_cfg, OFF_IO_END);

    assign up_bus_d = wr_up ? lane_data(i_cfg, OFF_UP_BUS) : up_bus_q;
    assign dn_bus_d = wr_dn ? lane_data(i_cfg, OFF_DN_BUS) : dn_bus_q;
    assign high_bus_d = wr_high ? lane_data(i_cfg, OFF_HIGH_BUS) : high_bus_q;
    assign lat_d = wr_lat ? lane_data(i_cfg, OFF_LAT_TIMER) : lat_q;
    // only the upper nibble is stored; the low nibble is a constant
    assign io_start_nib_d = wr_io_start ? io_start_wbyte[7:IO_NIB_LSB] : io_start_nib_q;
    assign io_end_nib_d = wr_io_end ? io_end_wbyte[7:IO_NIB_LSB] : io_end_nib_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            up_bus_q <= RST_BUS_NUM;
            dn_bus_q <= RST_BUS_NUM;
            high_bus_q <= RST_BUS_NUM;
            lat_q <= RST_LAT_TIMER;
            io_start_nib_q <= RST_IO_NIBBLE;
            io_end_nib_q <= RST_IO_NIBBLE;
        end else begin
            up_bus_q <= up_bus_d;
            dn_bus_q <= dn_bus_d;
            high_bus_q <= high_bus_d;
            lat_q <= lat_d;
            io_start_nib_q <= io_start_nib_d;
            io_end_nib_q <= io_end_nib_d;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire logic [7:0] io_start_byte = {io_start_nib_q, IO_ADDR_CAP};
    wire logic [7:0] io_end_byte = {io_end_nib_q, IO_ADDR_CAP};

    // bytes 1Eh and 1Fh belong to another block and read zero here
    wire logic [31:0] dw_hdr = place(RST_HEADER_TYPE, OFF_HEADER_TYPE)
        | place(RST_SELF_TEST, OFF_SELF_TEST);
    wire logic [31:0] dw_win0 = RST_RES_WIN;
    wire logic [31:0] dw_win1 = RST_RES_WIN;
    wire logic [31:0] dw_bus = place(up_bus_q, OFF_UP_BUS)
        | place(dn_bus_q, OFF_DN_BUS)
        | place(high_bus_q, OFF_HIGH_BUS)
        | place(lat_q, OFF_LAT_TIMER);
    wire logic [31:0] dw_io = place(io_start_byte, OFF_IO_START)
        | place(io_end_byte, OFF_IO_END);

    wire logic [5:0] rd_dw = i_cfg.addr[7:2];
    wire logic [31:0] rd_mux =
        (rd_dw == OFF_HEADER_TYPE[7:2]) ? dw_hdr :
        (rd_dw == OFF_RES_WIN0[7:2]) ? dw_win0 :
        (rd_dw == OFF_RES_WIN1[7:2]) ? dw_win1 :
        (rd_dw == OFF_UP_BUS[7:2]) ? dw_bus :
        (rd_dw == OFF_IO_START[7:2]) ? dw_io : 32'h0000_0000;

    logic [31:0] rdata_q;
    logic rvalid_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= i_cfg.rd;
            if (i_cfg.rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign o_cfg_rdata = rdata_q;
    assign o_cfg_rvalid = rvalid_q;

    // ------------------------------------------------------------
    // configuration forwarding decode
    // ------------------------------------------------------------
    // a bus number equal to the upstream one is never ours to claim
    wire logic fwd_in_range = (i_fwd.bus >= dn_bus_q) && (i_fwd.bus <= high_bus_q)
        && (i_fwd.bus != up_bus_q);
    wire logic fwd_to_dn = fwd_in_range && (i_fwd.bus == dn_bus_q);
    wire fwd_kind_t fwd_kind_d = !fwd_in_range ? FWD_NONE :
        fwd_to_dn ? FWD_TYPE0 : FWD_TYPE1;

    fwd_kind_t fwd_kind_q;
    logic fwd_done_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            fwd_kind_q <= FWD_NONE;
            fwd_done_q <= 1'b0;
        end else begin
            fwd_done_q <= i_fwd.valid;
            if (i_fwd.valid) begin
                fwd_kind_q <= fwd_kind_d;
            end
        end
    end

    assign o_fwd_done = fwd_done_q;
    assign o_fwd_kind = fwd_kind_q;

    // ------------------------------------------------------------
    // io window decode
    // ------------------------------------------------------------
    wire logic [31:0] io_start_addr = {i_io_start_upper, io_start_nib_q, IO_LOW_START};
    wire logic [31:0] io_end_addr = {i_io_end_upper, io_end_nib_q, IO_LOW_END};
    wire logic io_hit = (i_io_addr >= io_start_addr) && (i_io_addr <= io_end_addr);

    logic io_fwd_q;
    logic io_done_q;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            io_fwd_q <= 1'b0;
            io_done_q <= 1'b0;
        end else begin
            io_done_q <= i_io_valid;
            if (i_io_valid) begin
                io_fwd_q <= io_hit;
            end
        end
    end

    assign o_io_done = io_done_q;
    assign o_io_fwd = io_fwd_q;

    // ------------------------------------------------------------
    // downstream grant and latency termination
    // ------------------------------------------------------------
    logic lat_active;
    logic lat_expired;
    logic term_q;

    sec_latency_timer #(
        .CNT_W(LAT_W)
    ) u_lat (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_frame_start(i_sec_frame_start),
        .i_txn_end(i_sec_txn_end),
        .i_limit(lat_q),
        .o_active(lat_active),
        .o_expired(lat_expired)
    );

    assign o_sec_gnt = !i_other_master_req;
    wire logic term_d = lat_expired && lat_active && !o_sec_gnt && !i_sec_txn_end;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            term_q <= 1'b0;
        end else begin
            term_q <= term_d;
        end
    end

    assign o_lat_expired = lat_expired;
    assign o_sec_terminate = term_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_HDR_READ: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cfg.rd && i_cfg.addr[7:2] == OFF_HEADER_TYPE[7:2]
        |=> o_cfg_rvalid && o_cfg_rdata[23:16] == 8'h01 && o_cfg_rdata[31:24] == 8'h00)
        else $error("header or self test byte wrong");

    AST_WIN_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_cfg.rd && (i_cfg.addr[7:2] == OFF_RES_WIN0[7:2]
            || i_cfg.addr[7:2] == OFF_RES_WIN1[7:2])
        |=> o_cfg_rdata == 32'h0000_0000)
        else $error("resource window not zero");

    AST_BUS_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_up |=> up_bus_q == $past(i_cfg.wdata[7:0]))
        else $error("upstream bus number not stored");

    AST_DN_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_dn |=> dn_bus_q == $past(i_cfg.wdata[15:8]))
        else $error("downstream bus number not stored");

    AST_IO_START_WRITE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        wr_io_start |=> io_start_byte == {$past(i_cfg.wdata[7:4]), 4'h1})
        else $error("io start nibble not stored");

    AST_IO_CAP_BITS: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_cfg_rvalid && $past(i_cfg.addr[7:2]) == OFF_IO_START[7:2]
        |-> o_cfg_rdata[3:0] == 4'h1 && o_cfg_rdata[11:8] == 4'h1)
        else $error("io capability bits wrong");

    AST_FWD_TYPE0: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_fwd.valid && i_fwd.bus == dn_bus_q && i_fwd.bus <= high_bus_q
            && i_fwd.bus != up_bus_q
        |=> o_fwd_done && o_fwd_kind == FWD_TYPE0)
        else $error("downstream bus cycle not type 0");

    AST_FWD_TYPE1: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_fwd.valid && i_fwd.bus > dn_bus_q && i_fwd.bus <= high_bus_q
            && i_fwd.bus != up_bus_q
        |=> o_fwd_kind == FWD_TYPE1)
        else $error("deeper bus cycle not type 1");

    AST_FWD_NONE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_fwd.valid && (i_fwd.bus < dn_bus_q || i_fwd.bus > high_bus_q)
        |=> o_fwd_kind == FWD_NONE)
        else $error("out of range cycle claimed");

    AST_IO_WINDOW: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_io_valid && i_io_addr[31:16] == i_io_start_upper
            && i_io_start_upper == i_io_end_upper
            && i_io_addr[15:12] >= io_start_nib_q && i_io_addr[15:12] <= io_end_nib_q
        |=> o_io_done && o_io_fwd)
        else $error("io address inside window not forwarded");

    AST_GNT_WITHDRAW: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_other_master_req |-> !o_sec_gnt)
        else $error("grant kept while another master requests");

    AST_TERMINATE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        lat_expired && lat_active && i_other_master_req && !i_sec_txn_end
        |=> o_sec_terminate)
        else $error("expired timer did not terminate");

    AST_NO_EARLY_TERM: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !lat_expired |=> !o_sec_terminate)
        else $error("terminated before timer expiry");

    AST_IO_OUTSIDE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_io_valid && i_io_addr[31:16] == i_io_start_upper
            && i_io_start_upper == i_io_end_upper
            && (i_io_addr[15:12] < io_start_nib_q || i_io_addr[15:12] > io_end_nib_q)
        |=> o_io_done && !o_io_fwd)
        else $error("io address outside window forwarded");

endmodule

`default_nettype wire

// ### bridge_cfg_pkg.sv
// constants, types and notes for the bridge configuration register block
// Functional notes
// - header layout byte reads 01h always, writes ignored
// - self test unsupported; byte at 0Fh reads 00h always
// - resource window zero at 10h is read-only and reads all zeros
// - resource window one at 14h is read-only and reads all zeros
// - upstream bus number at 18h, read/write, resets to 00h
// - configuration forwarding decided from upstream, downstream and highest bus numbers
// - downstream bus number at 19h, read/write, resets to 00h
// - cycle aimed at downstream bus goes out as type 0
// - highest bus behind at 1Ah, read/write, resets to 00h
// - cycle aimed at deeper bus crosses unchanged as type 1
// - latency timer at 1Bh, read/write, reset 0, counts from 0 at frame start
// - expired timer ends the transaction once grant is withdrawn
// - internal downstream grant withdrawn when another master requests
// - io window low bytes, bits 3 to 0 fixed 0001b
// - io start nibble gives address bits 15:12, low 12 bits zero
// - io start upper 16 bits come from separate upper register
// - io end nibble gives address bits 15:12, low 12 bits all ones
// - io end upper 16 bits come from separate upper register
`default_nettype none

package bridge_cfg_pkg;

    // ------------------------------------------------------------
    // byte offsets in configuration space
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_HEADER_TYPE = 8'h0e;
    localparam logic [7:0] OFF_SELF_TEST = 8'h0f;
    localparam logic [7:0] OFF_RES_WIN0 = 8'h10;
    localparam logic [7:0] OFF_RES_WIN1 = 8'h14;
    localparam logic [7:0] OFF_UP_BUS = 8'h18;
    localparam logic [7:0] OFF_DN_BUS = 8'h19;
    localparam logic [7:0] OFF_HIGH_BUS = 8'h1a;
    localparam logic [7:0] OFF_LAT_TIMER = 8'h1b;
    localparam logic [7:0] OFF_IO_START = 8'h1c;
    localparam logic [7:0] OFF_IO_END = 8'h1d;

    // ------------------------------------------------------------
    // reset and fixed values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_HEADER_TYPE = 8'h01;
    localparam logic [7:0] RST_SELF_TEST = 8'h00;
    localparam logic [31:0] RST_RES_WIN = 32'h0000_0000;
    localparam logic [7:0] RST_BUS_NUM = 8'h00;
    localparam logic [7:0] RST_LAT_TIMER = 8'h00;
    localparam logic [3:0] RST_IO_NIBBLE = 4'h0;

    // ------------------------------------------------------------
    // io window field layout
    // ------------------------------------------------------------
    localparam logic [3:0] IO_ADDR_CAP = 4'h1;
    localparam int IO_NIB_LSB = 4;
    localparam logic [11:0] IO_LOW_START = 12'h000;
    localparam logic [11:0] IO_LOW_END = 12'hfff;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] bus;
    } cfg_fwd_req_t;

    typedef enum logic [1:0] {
        FWD_NONE,
        FWD_TYPE0,
        FWD_TYPE1
    } fwd_kind_t;

endpackage

`default_nettype wire

// ### sec_latency_timer.sv
// downstream latency timer counting clocks from frame start
`default_nettype none

module sec_latency_timer
    import bridge_cfg_pkg::*;
#(
    parameter int CNT_W = 8
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // control
    input wire logic i_frame_start,
    input wire logic i_txn_end,
    input wire logic [CNT_W-1:0] i_limit,
    // status
    output logic o_active,
    output logic o_expired
);

    if (CNT_W < 1 || CNT_W > 16) begin : g_chk
        $error("sec_latency_timer: CNT_W out of range");
    end

    logic [CNT_W-1:0] count_q, count_d;
    logic active_q, active_d;
    logic expired_q, expired_d;
    wire logic at_max = &count_q;

    // ------------------------------------------------------------
    // counter, restarts at zero on every frame start
    // ------------------------------------------------------------
    always_comb begin
        count_d = count_q;
        active_d = active_q;
        if (i_frame_start) begin
            count_d = '0;
            active_d = 1'b1;
        end else if (i_txn_end) begin
            active_d = 1'b0;
        end else if (active_q && !at_max) begin
            count_d = count_q + 1'b1;
        end
        expired_d = active_d && (count_d >= i_limit);
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            count_q <= '0;
            active_q <= 1'b0;
            expired_q <= 1'b0;
        end else begin
            count_q <= count_d;
            active_q <= active_d;
            expired_q <= expired_d;
        end
    end

    assign o_active = active_q;
    assign o_expired = expired_q;

    AST_TIMER_RESTART: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_frame_start |=> (count_q == '0) && active_q)
        else $error("timer did not restart at zero");

endmodule

`default_nettype wire

// ### cfg_host.sv
// host model issuing configuration cycles to the register block
`default_nettype none

module cfg_host
    import bridge_cfg_pkg::*;
(
    // clock
    input wire logic i_clk_sys,
    // request to the block
    output var cfg_req_t o_cfg,
    // answer from the block
    input wire logic [31:0] i_rdata,
    input wire logic i_rvalid
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_cfg = '0;
    end

    // released address and data lines never keep their last value
    task automatic idle();
        o_cfg.wr <= 1'b0;
        o_cfg.rd <= 1'b0;
        o_cfg.addr <= ~o_cfg.addr;
        o_cfg.wdata <= ~o_cfg.wdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge i_clk_sys);
        o_cfg <= '{1'b1, 1'b0, a, be, d};
        @(posedge i_clk_sys);
        idle();
    endtask

    // answer stands for one cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
        @(posedge i_clk_sys);
        o_cfg <= '{1'b0, 1'b1, a, 4'hf, ~o_cfg.wdata};
        @(posedge i_clk_sys);
        idle();
        #1;
        d = i_rdata;
        v = i_rvalid;
    endtask
endmodule

`default_nettype wire

// ### bridge_cfg_bus_io_regs_bench.sv
// self-checking bench for the configuration register block
`default_nettype none

module bridge_cfg_bus_io_regs_bench;
    import bridge_cfg_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic i_clk_sys, i_rst, i_io_valid, i_sec_frame_start, i_sec_txn_end, i_other_master_req;
    logic [15:0] i_io_start_upper, i_io_end_upper;
    logic [31:0] i_io_addr, o_cfg_rdata;
    logic o_cfg_rvalid, o_fwd_done, o_io_done, o_io_fwd, o_sec_gnt, o_lat_expired;
    logic o_sec_terminate;
    cfg_req_t i_cfg;
    cfg_fwd_req_t i_fwd;
    fwd_kind_t o_fwd_kind;
    int n_errors = 0;
    int n_checks = 0;

    bridge_cfg_bus_io_regs #(.LAT_W(8)) i_bridge_cfg_bus_io_regs (
        .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cfg(i_cfg), .o_cfg_rdata(o_cfg_rdata),
        .o_cfg_rvalid(o_cfg_rvalid), .i_io_start_upper(i_io_start_upper),
        .i_io_end_upper(i_io_end_upper), .i_fwd(i_fwd), .o_fwd_done(o_fwd_done),
        .o_fwd_kind(o_fwd_kind), .i_io_valid(i_io_valid), .i_io_addr(i_io_addr),
        .o_io_done(o_io_done), .o_io_fwd(o_io_fwd), .i_sec_frame_start(i_sec_frame_start),
        .i_sec_txn_end(i_sec_txn_end), .i_other_master_req(i_other_master_req),
        .o_sec_gnt(o_sec_gnt), .o_lat_expired(o_lat_expired), .o_sec_terminate(o_sec_terminate));

    cfg_host i_cfg_host (
        .i_clk_sys(i_clk_sys), .o_cfg(i_cfg), .i_rdata(o_cfg_rdata), .i_rvalid(o_cfg_rvalid));

    // ----------------------------------------
    // clock, checks, verdict
    // ----------------------------------------
    initial begin
        i_clk_sys = 1'b0;
        forever #12.5 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] d;
        logic v;
        i_cfg_host.rd(a, d, v);
        check("rvalid", {31'h0, v}, 32'h1);
        check($sformatf("rdata at %h", a), d & m, exp);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_vals();
        rd_chk(8'h0c, 32'h0001_0000, 32'hffff_0000);
        rd_chk(8'h10, 32'h0, 32'hffff_ffff);
        rd_chk(8'h14, 32'h0, 32'hffff_ffff);
        rd_chk(8'h18, 32'h0, 32'hffff_ffff);
        rd_chk(8'h1c, 32'h0000_0101, 32'hffff_ffff);
        rd_chk(8'h20, 32'h0, 32'hffff_ffff);
    endtask

    task automatic t_ro_writes();
        i_cfg_host.wr(8'h0c, 4'hc, 32'hffff_ffff);
        i_cfg_host.wr(8'h10, 4'hf, 32'hffff_ffff);
        i_cfg_host.wr(8'h14, 4'hf, 32'hffff_ffff);
        i_cfg_host.wr(8'h1c, 4'hf, 32'hffff_3020);
        rd_chk(8'h0c, 32'h0001_0000, 32'hffff_0000);
        rd_chk(8'h10, 32'h0, 32'hffff_ffff);
        rd_chk(8'h14, 32'h0, 32'hffff_ffff);
        rd_chk(8'h1c, 32'h0000_3121, 32'hffff_ffff);
    endtask

    task automatic t_bus_regs();
        i_cfg_host.wr(8'h18, 4'hf, 32'h0305_0201);
        rd_chk(8'h18, 32'h0305_0201, 32'hffff_ffff);
        i_cfg_host.wr(8'h18, 4'h1, 32'hffff_ff07);
        rd_chk(8'h18, 32'h0305_0207, 32'hffff_ffff);
        i_cfg_host.wr(8'h18, 4'h1, 32'h0000_0001);
    endtask

    // upstream 1, downstream 2, highest 5; then upstream moved to 3
    task automatic t_fwd();
        fwd_kind_t exp;
        for (int b = 0; b < 7; b++) begin
            exp = (b == 2) ? FWD_TYPE0 : (b > 2 && b <= 5) ? FWD_TYPE1 : FWD_NONE;
            @(posedge i_clk_sys);
            i_fwd <= '{1'b1, 8'(b)};
            @(posedge i_clk_sys);
            i_fwd <= '{1'b0, ~8'(b)};
            #1;
            check("fwd_done", {31'h0, o_fwd_done}, 32'h1);
            check("fwd_kind", {30'h0, o_fwd_kind}, {30'h0, exp});
        end
        i_cfg_host.wr(8'h18, 4'h1, 32'h0000_0003);
        @(posedge i_clk_sys);
        i_fwd <= '{1'b1, 8'h03};
        @(posedge i_clk_sys);
        i_fwd <= '{1'b0, 8'hfc};
        #1;
        check("fwd_kind up", {30'h0, o_fwd_kind}, {30'h0, FWD_NONE});
    endtask

    // start nibble 2, end nibble 3 from the earlier write
    task automatic t_io();
        logic [31:0] addrs [5] = '{32'h0001_1fff, 32'h0001_2000, 32'h0001_3fff,
            32'h0001_4000, 32'h0002_2000};
        logic [31:0] lo, hi;
        logic hit;
        lo = {16'h0001, 4'h2, IO_LOW_START};
        hi = {16'h0001, 4'h3, IO_LOW_END};
        @(posedge i_clk_sys);
        i_io_start_upper <= 16'h0001;
        i_io_end_upper <= 16'h0001;
        foreach (addrs[k]) begin
            @(posedge i_clk_sys);
            i_io_valid <= 1'b1;
            i_io_addr <= addrs[k];
            @(posedge i_clk_sys);
            i_io_valid <= 1'b0;
            i_io_addr <= ~addrs[k];
            #1;
            hit = addrs[k] >= lo && addrs[k] <= hi;
            check("io_done", {31'h0, o_io_done}, 32'h1);
            check("io_fwd", {31'h0, o_io_fwd}, {31'h0, hit});
        end
    endtask

    task automatic t_latency();
        i_cfg_host.wr(8'h18, 4'h8, 32'h0200_0000);
        @(posedge i_clk_sys);
        i_sec_frame_start <= 1'b1;
        @(posedge i_clk_sys);
        i_sec_frame_start <= 1'b0;
        @(posedge i_clk_sys);
        #1;
        check("expired early", {31'h0, o_lat_expired}, 32'h0);
        @(posedge i_clk_sys);
        #1;
        check("expired", {31'h0, o_lat_expired}, 32'h1);
        check("gnt before", {31'h0, o_sec_gnt}, 32'h1);
        @(posedge i_clk_sys);
        i_other_master_req <= 1'b1;
        #1;
        check("terminate early", {31'h0, o_sec_terminate}, 32'h0);
        check("gnt", {31'h0, o_sec_gnt}, 32'h0);
        @(posedge i_clk_sys);
        i_sec_txn_end <= 1'b1;
        #1;
        check("terminate", {31'h0, o_sec_terminate}, 32'h1);
        @(posedge i_clk_sys);
        i_sec_txn_end <= 1'b0;
        i_other_master_req <= 1'b0;
        #1;
        check("expired after end", {31'h0, o_lat_expired}, 32'h0);
        check("terminate after end", {31'h0, o_sec_terminate}, 32'h0);
        check("gnt back", {31'h0, o_sec_gnt}, 32'h1);
    endtask

    // registers written earlier must fall back to their reset values
    task automatic t_mid_reset();
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd_chk(8'h18, 32'h0, 32'hffff_ffff);
        rd_chk(8'h1c, 32'h0000_0101, 32'hffff_ffff);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        #100us;
        n_errors++;
        test_done();
    end

    initial begin
        i_rst = 1'b1;
        i_fwd = '0;
        i_io_valid = 1'b0;
        i_io_addr = 32'h0;
        i_io_start_upper = 16'h0;
        i_io_end_upper = 16'h0;
        i_sec_frame_start = 1'b0;
        i_sec_txn_end = 1'b0;
        i_other_master_req = 1'b0;
        repeat (12) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_reset_vals();
        t_ro_writes();
        t_bus_regs();
        t_fwd();
        t_io();
        t_latency();
        t_mid_reset();
        test_done();
    end
endmodule

`default_nettype wire
